// ### pkg/drcv_pkg.sv
package drcv_pkg;

    // Message type codes on the protocol-layer port; local encoding
    localparam logic [3:0] MSG_NONE          = 4'h0;
    localparam logic [3:0] MSG_GET_SRC_CAP   = 4'h1;
    localparam logic [3:0] MSG_GET_SNK_CAP   = 4'h2;
    localparam logic [3:0] MSG_SRC_CAP       = 4'h3;
    localparam logic [3:0] MSG_SNK_CAP       = 4'h4;
    localparam logic [3:0] MSG_GET_SRC_CAP_X = 4'h5;
    localparam logic [3:0] MSG_SRC_CAP_X     = 4'h6;
    localparam logic [3:0] MSG_VCONN_SWAP    = 4'h7;
    localparam logic [3:0] MSG_ACCEPT        = 4'h8;
    localparam logic [3:0] MSG_REJECT        = 4'h9;
    localparam logic [3:0] MSG_WAIT          = 4'ha;
    localparam logic [3:0] MSG_PS_RDY        = 4'hb;

    // Result codes reported to the policy manager
    localparam logic [1:0] RES_CAPS    = 2'h0;
    localparam logic [1:0] RES_TIMEOUT = 2'h1;
    localparam logic [1:0] RES_REJECT  = 2'h2;

    // Timer figures
    localparam int CLK_PERIOD_PS        = 4000;
    localparam int REPLY_WAIT_US        = 27;
    localparam int SUPPLY_ON_US         = 100;
    localparam int REPLY_WAIT_CYCLES    = (REPLY_WAIT_US * 1000000) / CLK_PERIOD_PS;
    localparam int SUPPLY_ON_CYCLES     = (SUPPLY_ON_US * 1000000) / CLK_PERIOD_PS;
    localparam int TMR_W                = 16;
    localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
    localparam logic [TMR_W-1:0] TMR_ONE  = 16'h0001;

    typedef enum logic [15:0] {
        ST_SRC_READY    = 16'h0001,
        ST_SNK_READY    = 16'h0002,
        ST_SRC_FETCH    = 16'h0004,
        ST_SRC_OFFER    = 16'h0008,
        ST_SNK_FETCH    = 16'h0010,
        ST_SNK_OFFER    = 16'h0020,
        ST_SRC_FETCH_X  = 16'h0040,
        ST_SNK_OFFER_X  = 16'h0080,
        ST_VCS_REQUEST  = 16'h0100,
        ST_VCS_EVAL     = 16'h0200,
        ST_VCS_ACCEPT   = 16'h0400,
        ST_VCS_REFUSE   = 16'h0800,
        ST_VCS_WAIT     = 16'h1000,
        ST_VCS_OFF      = 16'h2000,
        ST_VCS_ON       = 16'h4000,
        ST_VCS_PS_RDY   = 16'h8000
    } drcv_state_t;

endpackage

// ### core/drcv_timer.sv
`timescale 1ns/10ps
module drcv_timer
    import drcv_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic [TMR_W-1:0] load,
    // Status
    output logic                  expired
);

    logic [TMR_W-1:0] count;
    logic             running;

    // Expiry is a one-cycle pulse on the last count
    assign expired = running && (count == TMR_ONE);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= TMR_ZERO;
            running <= 1'b0;
        end else if (start) begin
            count   <= load;
            running <= 1'b1;
        end else if (stop || expired) begin
            count   <= TMR_ZERO;
            running <= 1'b0;
        end else if (running) begin
            count   <= count - TMR_ONE;
        end
    end

endmodule

// ### core/drcv_sync.sv
`timescale 1ns/10ps
module drcv_sync (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Level in and out
    input  wire logic din,
    output logic      dout
);

    logic meta;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

// ### core/drcv_engine.sv
`timescale 1ns/10ps
module drcv_engine
    import drcv_pkg::*;
#(
    parameter int REPLY_WAIT_LOAD = REPLY_WAIT_CYCLES,
    parameter int SUPPLY_ON_LOAD  = SUPPLY_ON_CYCLES
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Power role after reset: 1 = source
    input  wire logic       role_is_source,
    // Policy manager requests, one-cycle pulses
    input  wire logic       pm_get_src_caps,
    input  wire logic       pm_get_snk_caps,
    input  wire logic       pm_get_src_caps_ext,
    input  wire logic       pm_vconn_swap,
    // Policy manager status
    input  wire logic       pm_is_vconn_source,
    input  wire logic       pm_caps_valid,
    input  wire logic       pm_eval_done,
    input  wire logic       pm_eval_ok,
    input  wire logic       pm_eval_wait,
    input  wire logic       vconn_on,
    // Policy manager outputs
    output logic            pm_caps_req,
    output logic            pm_eval_req,
    output logic            vconn_enable,
    output logic            result_valid,
    output logic [1:0]      result_code,
    output logic [3:0]      result_msg,
    output logic            hard_reset_src,
    output logic            hard_reset_snk,
    // Protocol layer receive
    input  wire logic       rx_valid,
    input  wire logic [3:0] rx_msg,
    // Protocol layer transmit
    output logic            tx_valid,
    output logic [3:0]      tx_msg,
    input  wire logic       tx_done,
    // State view
    output drcv_state_t     state
);

    localparam logic [TMR_W-1:0] REPLY_LOAD = TMR_W'(REPLY_WAIT_LOAD);
    localparam logic [TMR_W-1:0] ON_LOAD    = TMR_W'(SUPPLY_ON_LOAD);

    logic        rst_meta;
    logic        rst_sync_n;
    logic        vconn_on_s;
    logic        role_src_s;
    drcv_state_t next_state;
    logic        tmr_start;
    logic        tmr_stop;
    logic [TMR_W-1:0] tmr_load;
    logic        tmr_expired;
    logic        tx_pending;
    logic        next_tx_valid;
    logic [3:0]  next_tx_msg;
    logic        entering;
    logic        rx_is;

    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // VCONN status comes from the supply switch, outside this clock
    drcv_sync u_sync_vconn (
        .sys_clk (sys_clk),
        .rst_n   (rst_sync_n),
        .din     (vconn_on),
        .dout    (vconn_on_s)
    );

    drcv_sync u_sync_role (
        .sys_clk (sys_clk),
        .rst_n   (rst_sync_n),
        .din     (role_is_source),
        .dout    (role_src_s)
    );

    drcv_timer u_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_sync_n),
        .start   (tmr_start),
        .stop    (tmr_stop),
        .load    (tmr_load),
        .expired (tmr_expired)
    );

    function automatic logic got(input logic v, input logic [3:0] m, input logic [3:0] w);
        got = v && (m == w);
    endfunction

    function automatic drcv_state_t ready_of(input logic src);
        ready_of = src ? ST_SRC_READY : ST_SNK_READY;
    endfunction

    // After an accepted swap, VCONN level picks the next step
    function automatic drcv_state_t after_accept(input logic on);
        after_accept = on ? ST_VCS_WAIT : ST_VCS_ON;
    endfunction

    assign rx_is = rx_valid;

    // Role tracking: ready states carry the role
    logic       in_src_role;
    logic       role_loaded;
    logic [1:0] role_settle;
    logic       role_ready;

    // The role synchroniser shows the pin only two edges after reset release
    assign role_ready = role_settle[1];

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            role_settle <= 2'h0;
            role_loaded <= 1'b0;
            in_src_role <= 1'b0;
        end else begin
            role_settle <= {role_settle[0], 1'b1};
            if (role_ready && !role_loaded) begin
                role_loaded <= 1'b1;
                in_src_role <= role_src_s;
            end
        end
    end

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            ST_SRC_READY: begin
                if (!role_loaded)
                    next_state = role_ready ? ready_of(role_src_s) : state;
                else if (got(rx_is, rx_msg, MSG_GET_SNK_CAP))
                    next_state = ST_SRC_OFFER;
                else if (got(rx_is, rx_msg, MSG_VCONN_SWAP))
                    next_state = ST_VCS_EVAL;
                else if (pm_get_src_caps)
                    next_state = ST_SRC_FETCH;
                else if (pm_get_src_caps_ext)
                    next_state = ST_SRC_FETCH_X;
                else if (pm_vconn_swap && pm_is_vconn_source)
                    next_state = ST_VCS_REQUEST;
            end
            ST_SNK_READY: begin
                if (!role_loaded)
                    next_state = role_ready ? ready_of(role_src_s) : state;
                else if (got(rx_is, rx_msg, MSG_GET_SRC_CAP))
                    next_state = ST_SNK_OFFER;
                else if (got(rx_is, rx_msg, MSG_GET_SRC_CAP_X))
                    next_state = ST_SNK_OFFER_X;
                else if (got(rx_is, rx_msg, MSG_VCONN_SWAP))
                    next_state = ST_VCS_EVAL;
                else if (pm_get_snk_caps)
                    next_state = ST_SNK_FETCH;
                else if (pm_vconn_swap && pm_is_vconn_source)
                    next_state = ST_VCS_REQUEST;
            end
            ST_SRC_FETCH: begin
                if (got(rx_is, rx_msg, MSG_SRC_CAP) || got(rx_is, rx_msg, MSG_REJECT)
                    || tmr_expired)
                    next_state = ST_SRC_READY;
            end
            ST_SNK_FETCH: begin
                if (got(rx_is, rx_msg, MSG_SNK_CAP) || got(rx_is, rx_msg, MSG_SRC_CAP)
                    || got(rx_is, rx_msg, MSG_REJECT) || tmr_expired)
                    next_state = ST_SNK_READY;
            end
            ST_SRC_FETCH_X: begin
                if (got(rx_is, rx_msg, MSG_SRC_CAP_X) || tmr_expired)
                    next_state = ST_SRC_READY;
            end
            ST_SRC_OFFER: begin
                if (tx_done && !tx_pending)
                    next_state = ST_SRC_READY;
            end
            ST_SNK_OFFER, ST_SNK_OFFER_X: begin
                if (tx_done && !tx_pending)
                    next_state = ST_SNK_READY;
            end
            ST_VCS_REQUEST: begin
                if (got(rx_is, rx_msg, MSG_ACCEPT))
                    next_state = after_accept(vconn_on_s);
                else if (got(rx_is, rx_msg, MSG_REJECT) || got(rx_is, rx_msg, MSG_WAIT)
                         || tmr_expired)
                    next_state = ready_of(in_src_role);
            end
            ST_VCS_EVAL: begin
                if (pm_eval_done)
                    next_state = pm_eval_ok ? ST_VCS_ACCEPT : ST_VCS_REFUSE;
            end
            ST_VCS_ACCEPT: begin
                if (tx_done && !tx_pending)
                    next_state = after_accept(vconn_on_s);
            end
            ST_VCS_REFUSE: begin
                if (tx_done && !tx_pending)
                    next_state = ready_of(in_src_role);
            end
            ST_VCS_WAIT: begin
                if (got(rx_is, rx_msg, MSG_PS_RDY))
                    next_state = ST_VCS_OFF;
                else if (tmr_expired)
                    next_state = ready_of(in_src_role);
            end
            ST_VCS_OFF: begin
                if (!vconn_on_s)
                    next_state = ready_of(in_src_role);
            end
            ST_VCS_ON: begin
                if (vconn_on_s)
                    next_state = ST_VCS_PS_RDY;
            end
            ST_VCS_PS_RDY: begin
                if (tx_done && !tx_pending)
                    next_state = ready_of(in_src_role);
            end
            default: next_state = ST_SRC_READY;
        endcase
    end

    assign entering = (next_state != state);

    // Timer control on state entry
    assign tmr_start = entering && (next_state == ST_SRC_FETCH || next_state == ST_SNK_FETCH
                       || next_state == ST_SRC_FETCH_X || next_state == ST_VCS_REQUEST
                       || next_state == ST_VCS_WAIT);
    assign tmr_load  = (next_state == ST_VCS_WAIT) ? ON_LOAD : REPLY_LOAD;
    assign tmr_stop  = entering && !tmr_start;

    // Message launched on entry to a sending state
    always_comb begin
        next_tx_valid = 1'b0;
        next_tx_msg   = MSG_NONE;
        if (entering) begin
            next_tx_valid = 1'b1;
            case (next_state)
                ST_SRC_FETCH:   next_tx_msg = MSG_GET_SRC_CAP;
                ST_SNK_FETCH:   next_tx_msg = MSG_GET_SNK_CAP;
                ST_SRC_FETCH_X: next_tx_msg = MSG_GET_SRC_CAP_X;
                ST_VCS_REQUEST: next_tx_msg = MSG_VCONN_SWAP;
                ST_VCS_ACCEPT:  next_tx_msg = MSG_ACCEPT;
                ST_VCS_REFUSE:  next_tx_msg = pm_eval_wait ? MSG_WAIT : MSG_REJECT;
                ST_VCS_PS_RDY:  next_tx_msg = MSG_PS_RDY;
                default:        next_tx_valid = 1'b0;
            endcase
        end else if ((state == ST_SRC_OFFER || state == ST_SNK_OFFER) && pm_caps_valid
                     && tx_pending && !tx_valid) begin
            // Offers wait for the policy manager's caps before sending
            next_tx_valid = 1'b1;
            next_tx_msg   = (state == ST_SRC_OFFER) ? MSG_SNK_CAP : MSG_SRC_CAP;
        end else if (state == ST_SNK_OFFER_X && pm_caps_valid && tx_pending && !tx_valid) begin
            next_tx_valid = 1'b1;
            next_tx_msg   = MSG_SRC_CAP_X;
        end
    end

    // Offers hold tx_pending until the caps message is launched
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state      <= ST_SRC_READY;
            tx_valid   <= 1'b0;
            tx_msg     <= MSG_NONE;
            tx_pending <= 1'b0;
        end else begin
            state      <= next_state;
            tx_valid   <= next_tx_valid;
            tx_msg     <= next_tx_msg;
            if (entering)
                tx_pending <= (next_state == ST_SRC_OFFER || next_state == ST_SNK_OFFER
                               || next_state == ST_SNK_OFFER_X);
            else if (next_tx_valid)
                tx_pending <= 1'b0;
        end
    end

    // Policy manager level outputs
    assign pm_caps_req  = (state == ST_SRC_OFFER || state == ST_SNK_OFFER
                           || state == ST_SNK_OFFER_X) && tx_pending;
    assign pm_eval_req  = (state == ST_VCS_EVAL);

    // Result report and supply control, registered
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            result_valid   <= 1'b0;
            result_code    <= RES_CAPS;
            result_msg     <= MSG_NONE;
            vconn_enable   <= 1'b0;
            hard_reset_src <= 1'b0;
            hard_reset_snk <= 1'b0;
        end else begin
            result_valid   <= 1'b0;
            hard_reset_src <= 1'b0;
            hard_reset_snk <= 1'b0;
            if (entering && (state == ST_SRC_FETCH || state == ST_SNK_FETCH
                             || state == ST_SRC_FETCH_X)) begin
                result_valid <= 1'b1;
                result_msg   <= rx_is ? rx_msg : MSG_NONE;
                result_code  <= tmr_expired ? RES_TIMEOUT
                              : got(rx_is, rx_msg, MSG_REJECT) ? RES_REJECT : RES_CAPS;
            end
            if (state == ST_VCS_WAIT && tmr_expired && !got(rx_is, rx_msg, MSG_PS_RDY)) begin
                hard_reset_src <= in_src_role;
                hard_reset_snk <= !in_src_role;
            end
            if (next_state == ST_VCS_ON)
                vconn_enable <= 1'b1;
            else if (next_state == ST_VCS_OFF)
                vconn_enable <= 1'b0;
        end
    end

endmodule

// ### test/drcv_partner.sv
`timescale 1ns/10ps
module drcv_partner
    import drcv_pkg::*;
(
    // Clock
    input  wire logic       sys_clk,
    // Bench control
    input  wire logic [3:0] reply,
    input  wire logic       send,
    input  wire logic [3:0] send_msg,
    // Engine side
    input  wire logic       tx_valid,
    input  wire logic [3:0] tx_msg,
    output logic            tx_done,
    output logic            rx_valid,
    output logic [3:0]      rx_msg,
    output logic [3:0]      last_tx
);
    logic [3:0] r;
    initial begin
        tx_done = 1'b0;
        rx_valid = 1'b0;
        rx_msg = 4'h0;
        last_tx = 4'h0;
    end
    // Idle code lines flip so a stale code never reads as a fresh one
    task automatic push(input logic [3:0] m);
        #1 rx_valid = 1'b1;
        rx_msg = m;
        @(posedge sys_clk);
        #1 rx_valid = 1'b0;
        rx_msg = ~m;
    endtask
    always begin
        @(posedge sys_clk);
        if (send) begin
            push(send_msg);
        end else if (tx_valid) begin
            r = reply;
            last_tx = tx_msg;
            repeat (2) @(posedge sys_clk);
            #1 tx_done = 1'b1;
            @(posedge sys_clk);
            #1 tx_done = 1'b0;
            if (r != MSG_NONE) begin
                @(posedge sys_clk);
                push(r);
            end
        end
    end
endmodule

// ### test/drcv_engine_asserts.sv
`timescale 1ns/10ps
module drcv_engine_asserts
    import drcv_pkg::*;
#(
    parameter int REPLY_WAIT_LOAD = 20
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // Policy manager
    input wire logic        pm_get_src_caps,
    input wire logic        pm_vconn_swap,
    input wire logic        pm_is_vconn_source,
    input wire logic        pm_eval_done,
    input wire logic        pm_eval_ok,
    input wire logic        pm_eval_wait,
    input wire logic        vconn_on,
    input wire logic        pm_caps_req,
    input wire logic        pm_eval_req,
    input wire logic        vconn_enable,
    input wire logic        result_valid,
    input wire logic [1:0]  result_code,
    input wire logic        hard_reset_snk,
    // Protocol layer
    input wire logic        rx_valid,
    input wire logic [3:0]  rx_msg,
    input wire logic        tx_valid,
    input wire logic [3:0]  tx_msg,
    input wire logic        tx_done,
    input wire drcv_state_t state
);
    logic        rdy;
    logic        in_fetch;
    logic [15:0] fcnt;
    assign rdy = (state == ST_SRC_READY) || (state == ST_SNK_READY);
    assign in_fetch = state inside {ST_SRC_FETCH, ST_SNK_FETCH, ST_SRC_FETCH_X};
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) fcnt <= 16'h0000;
        else fcnt <= in_fetch ? fcnt + 16'h0001 : 16'h0000;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_FETCH_START: assert property (state == ST_SRC_READY && pm_get_src_caps && !rx_valid
        |=> state == ST_SRC_FETCH && tx_valid && tx_msg == MSG_GET_SRC_CAP)
        else $error("source caps fetch not launched");
    AST_FETCH_CAPS: assert property (state == ST_SRC_FETCH && rx_valid && rx_msg == MSG_SRC_CAP
        |=> state == ST_SRC_READY && result_valid && result_code == RES_CAPS)
        else $error("caps reply not reported");
    AST_FETCH_REJECT: assert property (state inside {ST_SRC_FETCH, ST_SNK_FETCH} && rx_valid
        && rx_msg == MSG_REJECT |=> rdy && result_valid && result_code == RES_REJECT)
        else $error("reject reply not handled");
    AST_FETCH_BOUND: assert property (in_fetch |-> fcnt <= REPLY_WAIT_LOAD + 2)
        else $error("fetch outlived the reply timer");
    AST_OFFER_DONE: assert property (state == ST_SRC_OFFER && !pm_caps_req && tx_done
        |=> state == ST_SRC_READY)
        else $error("sink caps offer did not return");
    AST_SWAP_START: assert property (rdy && pm_vconn_swap && pm_is_vconn_source && !rx_valid
        |=> state == ST_VCS_REQUEST && tx_valid && tx_msg == MSG_VCONN_SWAP)
        else $error("swap request not sent");
    AST_SWAP_ACCEPTED: assert property (state == ST_VCS_REQUEST && rx_valid && rx_msg == MSG_ACCEPT
        |=> state == ($past(vconn_on) ? ST_VCS_WAIT : ST_VCS_ON))
        else $error("accepted swap went wrong way");
    AST_EVAL_ENTRY: assert property (rdy && rx_valid && rx_msg == MSG_VCONN_SWAP
        |=> state == ST_VCS_EVAL && pm_eval_req)
        else $error("swap evaluation not requested");
    AST_EVAL_ANSWER: assert property (state == ST_VCS_EVAL && pm_eval_done |=> tx_valid
        && tx_msg == ($past(pm_eval_ok) ? MSG_ACCEPT : $past(pm_eval_wait) ? MSG_WAIT : MSG_REJECT))
        else $error("wrong answer to swap");
    AST_PARTNER_READY: assert property (state == ST_VCS_WAIT && rx_valid && rx_msg == MSG_PS_RDY
        |=> state == ST_VCS_OFF ##[0:1] !vconn_enable)
        else $error("supply not removed after partner ready");
    AST_SUPPLY_UP: assert property ($rose(state == ST_VCS_PS_RDY)
        |-> tx_valid && tx_msg == MSG_PS_RDY && vconn_enable)
        else $error("ready not sent with supply on");
    COV_PS_RDY: cover property (state == ST_VCS_WAIT && rx_valid && rx_msg == MSG_PS_RDY);
    COV_TIMEOUT: cover property (result_valid && result_code == RES_TIMEOUT);
    COV_HARD_RESET: cover property (hard_reset_snk);
endmodule

bind drcv_engine drcv_engine_asserts #(.REPLY_WAIT_LOAD(REPLY_WAIT_LOAD)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .pm_get_src_caps(pm_get_src_caps),
    .pm_vconn_swap(pm_vconn_swap), .pm_is_vconn_source(pm_is_vconn_source),
    .pm_eval_done(pm_eval_done), .pm_eval_ok(pm_eval_ok), .pm_eval_wait(pm_eval_wait),
    .vconn_on(vconn_on), .pm_caps_req(pm_caps_req), .pm_eval_req(pm_eval_req),
    .vconn_enable(vconn_enable), .result_valid(result_valid), .result_code(result_code),
    .hard_reset_snk(hard_reset_snk), .rx_valid(rx_valid), .rx_msg(rx_msg),
    .tx_valid(tx_valid), .tx_msg(tx_msg), .tx_done(tx_done), .state(state));

// ### test/testbench.sv
`timescale 1ns/10ps
module testbench
    import drcv_pkg::*;
;
    logic        sys_clk = 1'b0, rst_n = 1'b0, role = 1'b1, send = 1'b0, vconn_on = 1'b0;
    logic        g_src = 1'b0, g_snk = 1'b0, g_ext = 1'b0, g_swap = 1'b0, vsrc = 1'b1;
    logic        caps_ok = 1'b0, ev_done = 1'b0, ev_ok = 1'b0, ev_wait = 1'b0;
    logic [3:0]  reply = MSG_NONE, send_msg = MSG_NONE;
    logic        pm_caps_req, pm_eval_req, vconn_enable, result_valid, hr_src, hr_snk;
    logic        tx_valid, tx_done, rx_valid;
    logic [1:0]  result_code;
    logic [3:0]  result_msg, tx_msg, rx_msg, last_tx;
    drcv_state_t state, rdy = ST_SRC_READY;
    int          miscompares = 0, total_checks = 0, cyc = 0;

    always #2 sys_clk = ~sys_clk;
    // Supply follows its switch half a cycle late, on the falling edge
    always @(negedge sys_clk) vconn_on <= vconn_enable;

    drcv_engine #(.REPLY_WAIT_LOAD(20), .SUPPLY_ON_LOAD(40)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .role_is_source(role),
        .pm_get_src_caps(g_src), .pm_get_snk_caps(g_snk), .pm_get_src_caps_ext(g_ext),
        .pm_vconn_swap(g_swap), .pm_is_vconn_source(vsrc), .pm_caps_valid(caps_ok),
        .pm_eval_done(ev_done), .pm_eval_ok(ev_ok), .pm_eval_wait(ev_wait),
        .vconn_on(vconn_on), .pm_caps_req(pm_caps_req), .pm_eval_req(pm_eval_req),
        .vconn_enable(vconn_enable), .result_valid(result_valid),
        .result_code(result_code), .result_msg(result_msg), .hard_reset_src(hr_src),
        .hard_reset_snk(hr_snk), .rx_valid(rx_valid), .rx_msg(rx_msg),
        .tx_valid(tx_valid), .tx_msg(tx_msg), .tx_done(tx_done), .state(state));
    drcv_partner u_partner (
        .sys_clk(sys_clk), .reply(reply), .send(send), .send_msg(send_msg),
        .tx_valid(tx_valid), .tx_msg(tx_msg), .tx_done(tx_done),
        .rx_valid(rx_valid), .rx_msg(rx_msg), .last_tx(last_tx));

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_hi(input logic pick_hr);
        int n = 0;
        while ((pick_hr ? hr_snk : result_valid) !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    task wait_st(input drcv_state_t s);
        int n;
        n = 0;
        while (state !== s && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    task tell(input logic [3:0] m);
        @(negedge sys_clk);
        send_msg = m;
        send = 1'b1;
        @(negedge sys_clk);
        send = 1'b0;
    endtask
    task do_reset(input logic src);
        role = src;
        rdy = src ? ST_SRC_READY : ST_SNK_READY;
        @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk(state, rdy);
        chk(vconn_enable, 1'b0);
    endtask
    task t_fetch(input int k, input logic [3:0] r, input logic [1:0] code);
        reply = r;
        @(negedge sys_clk);
        g_src = (k == 0);
        g_snk = (k == 1);
        g_ext = (k == 2);
        @(negedge sys_clk);
        {g_src, g_snk, g_ext} = 3'h0;
        wait_hi(1'b0);
        chk(result_code, code);
        if (code == RES_CAPS) chk(result_msg, r);
        chk(state, rdy);
    endtask
    task t_offer(input logic [3:0] m, input logic [3:0] tx);
        caps_ok = 1'b0;
        tell(m);
        repeat (3) @(negedge sys_clk);
        chk(pm_caps_req, 1'b1);
        caps_ok = 1'b1;
        wait_st(rdy);
        chk(last_tx, tx);
        chk(state, rdy);
        caps_ok = 1'b0;
    endtask
    task t_swap(input logic [3:0] r, input drcv_state_t mid);
        logic [3:0] prev;
        prev = last_tx;
        reply = r;
        @(negedge sys_clk);
        g_swap = 1'b1;
        @(negedge sys_clk);
        g_swap = 1'b0;
        @(negedge sys_clk);
        reply = MSG_NONE;
        chk(last_tx, vsrc ? MSG_VCONN_SWAP : prev);
        wait_st(mid);
        chk(state, mid);
        if (mid == ST_VCS_WAIT) tell(MSG_PS_RDY);
        wait_st(rdy);
        chk(state, rdy);
        chk(vconn_enable, mid == ST_VCS_ON);
        chk(last_tx, mid == ST_VCS_ON ? MSG_PS_RDY : vsrc ? MSG_VCONN_SWAP : prev);
    endtask
    task t_resp(input logic ok, input logic wt, input logic ps);
        drcv_state_t e;
        e = vconn_on ? ST_VCS_WAIT : ST_VCS_ON;
        tell(MSG_VCONN_SWAP);
        wait_st(ST_VCS_EVAL);
        chk(pm_eval_req, 1'b1);
        @(negedge sys_clk);
        ev_done = 1'b1;
        ev_ok = ok;
        ev_wait = wt;
        @(negedge sys_clk);
        ev_done = 1'b0;
        if (!ok) begin
            wait_st(rdy);
            chk(last_tx, wt ? MSG_WAIT : MSG_REJECT);
        end else begin
            wait_st(e);
            chk(state, e);
            if (e == ST_VCS_WAIT && ps) tell(MSG_PS_RDY);
            if (e == ST_VCS_WAIT && !ps) wait_hi(1'b1);
            if (e == ST_VCS_WAIT && !ps) chk(hr_snk, 1'b1);
            if (e == ST_VCS_WAIT && !ps) chk(hr_src, 1'b0);
            wait_st(rdy);
            chk(vconn_enable, !(e == ST_VCS_WAIT && ps));
        end
        chk(state, rdy);
    endtask

    initial begin
        do_reset(1'b1);
        t_fetch(0, MSG_SRC_CAP, RES_CAPS);
        t_fetch(0, MSG_REJECT, RES_REJECT);
        t_fetch(0, MSG_NONE, RES_TIMEOUT);
        t_fetch(2, MSG_SRC_CAP_X, RES_CAPS);
        t_fetch(2, MSG_NONE, RES_TIMEOUT);
        t_offer(MSG_GET_SNK_CAP, MSG_SNK_CAP);
        // A port that does not own the supply may not ask for the swap
        vsrc = 1'b0;
        t_swap(MSG_NONE, rdy);
        vsrc = 1'b1;
        t_swap(MSG_REJECT, rdy);
        t_swap(MSG_WAIT, rdy);
        t_swap(MSG_NONE, rdy);
        t_swap(MSG_ACCEPT, ST_VCS_ON);
        t_swap(MSG_ACCEPT, ST_VCS_WAIT);
        do_reset(1'b0);
        t_fetch(1, MSG_SNK_CAP, RES_CAPS);
        t_fetch(1, MSG_REJECT, RES_REJECT);
        t_fetch(1, MSG_NONE, RES_TIMEOUT);
        t_offer(MSG_GET_SRC_CAP, MSG_SRC_CAP);
        t_offer(MSG_GET_SRC_CAP_X, MSG_SRC_CAP_X);
        t_resp(1'b0, 1'b0, 1'b0);
        t_resp(1'b0, 1'b1, 1'b0);
        // Partner asks again after being told to wait
        t_resp(1'b1, 1'b0, 1'b1);
        t_resp(1'b1, 1'b0, 1'b0);
        t_resp(1'b1, 1'b0, 1'b1);
        give_verdict;
    end
endmodule
